// ==== design/seal_consts.svh ====
// register offsets, field positions, response codes and timing counts of the eeprom loader
// assumes inclusion by bare name from the design file and the testbench
`ifndef SEAL_CONSTS_SVH
`define SEAL_CONSTS_SVH
`define SEAL_OFF_CTRL      8'h70
`define SEAL_OFF_IRQ_STAT  8'h74
`define SEAL_OFF_IRQ_MASK  8'h78
`define SEAL_OFF_LOAD_CNT  8'h7c
`define SEAL_B_START       0
`define SEAL_B_CMD         1
`define SEAL_B_ERR         2
`define SEAL_B_DONE        3
`define SEAL_B_DIV_LO      4
`define SEAL_B_DIV_HI      5
`define SEAL_B_AL_DIS      6
`define SEAL_B_FAST        7
`define SEAL_B_BUSY        8
`define SEAL_B_ADDR_LO     9
`define SEAL_B_ADDR_HI     15
`define SEAL_B_DATA_LO     16
`define SEAL_B_DATA_HI     31
`define SEAL_DIV_8192      14'h1fff
`define SEAL_DIV_4096      14'h0fff
`define SEAL_DIV_2048      14'h07ff
`define SEAL_DIV_256       14'h00ff
`define SEAL_FAST_SHIFT    3
`define SEAL_DEV_WR        8'ha0
`define SEAL_DEV_RD        8'ha1
`define SEAL_LOAD_WORDS    7'h10
`define SEAL_RESP_OKAY     2'h0
`define SEAL_RESP_SLVERR   2'h2
`define SEAL_IRQ_W         3
`define SEAL_IRQ_CYC       0
`define SEAL_IRQ_ERR       1
`define SEAL_IRQ_LOAD      2
`endif

// ==== design/seal_pkg.sv ====
// types shared by the eeprom loader
// uses nothing from the constants header
package seal_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_START, ST_BYTE, ST_ACK, ST_RBYTE, ST_MACK, ST_STOP
	} seal_state_e;
	typedef logic [15:0] seal_word_t;
endpackage

// ==== design/seal_top.sv ====
// serial eeprom access and autoload engine with an axi4-lite register slave
// assumes a two-wire eeprom with pull-ups outside and one 10 MHz clock, mclk
`timescale 1ns/1ps
`include "seal_consts.svh"

module seal_top (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             ee_scl_o,
	output logic             ee_scl_oe,
	output logic             ee_sda_o,
	output logic             ee_sda_oe,
	input  wire logic        ee_sda_i,
	output logic             load_we,
	output logic [6:0]       load_addr,
	output logic [15:0]      load_data,
	output logic             irq
);
	// control fields
	logic                 start_r, cmd_r, err_r, done_r, al_dis_r, fast_r, busy_r;
	logic [1:0]           div_r;
	logic [6:0]           addr_r;
	seal_pkg::seal_word_t data_r;
	logic [`SEAL_IRQ_W-1:0] ist_r, imask_r;
	logic [6:0]           load_cnt_r;
	// engine
	seal_pkg::seal_state_e st_r;
	logic [13:0]          div_cnt_r;
	logic [1:0]           ph_r;
	logic [2:0]           bit_r;
	logic [1:0]           byte_r;
	logic [7:0]           sh_r;
	seal_pkg::seal_word_t rx_r;
	logic                 is_auto_r, restart_r, nack_r, cyc_wr_r;
	logic                 al_pend_r;
	// bus
	logic                 aw_r, w_r;
	logic [7:0]           awa_r;
	logic [31:0]          wd_r;
	logic [3:0]           ws_r;
	logic                 wr_go, rd_go, fin, tick;
	logic [13:0]          div_lim;

	// divider limit; autoload in fast mode shortens the tick by eight
	function automatic logic [13:0] lim_of(input logic [1:0] sel, input logic fast);
		logic [13:0] l;
		l = `SEAL_DIV_8192;
		unique case (sel)
			2'h0: l = `SEAL_DIV_8192;
			2'h1: l = `SEAL_DIV_4096;
			2'h2: l = `SEAL_DIV_2048;
			2'h3: l = `SEAL_DIV_256;
		endcase
		if (fast)
			l = l >> `SEAL_FAST_SHIFT;
		return l;
	endfunction

	// quarter-period of the serial clock; four ticks per bit gives the full ratio
	assign div_lim = lim_of(div_r, fast_r & is_auto_r) >> 2;
	assign tick    = clk_en && (st_r != seal_pkg::ST_IDLE) && (div_cnt_r >= div_lim);

	// write channels are taken independently and answered once both arrived
	assign s_axi_awready = !aw_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_r && !s_axi_bvalid;
	assign wr_go = aw_r && w_r && !s_axi_bvalid && clk_en;
	assign rd_go = s_axi_arvalid && s_axi_arready && clk_en;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			aw_r <= 1'b0;
			w_r  <= 1'b0;
			awa_r <= 8'h00;
			wd_r <= 32'h0000_0000;
			ws_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SEAL_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_r  <= 1'b1;
				awa_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_r  <= 1'b1;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_r <= 1'b0;
				w_r  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awa_r[7:4] == 4'h7) ? `SEAL_RESP_OKAY : `SEAL_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read data is registered; unmapped words answer slave error with zero data
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `SEAL_RESP_OKAY;
		end else if (clk_en) begin
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `SEAL_RESP_OKAY;
				unique case ({s_axi_araddr[7:2], 2'b00})
					`SEAL_OFF_CTRL: s_axi_rdata <= {data_r, addr_r, busy_r, fast_r, al_dis_r,
						div_r, done_r, err_r, cmd_r, start_r};
					`SEAL_OFF_IRQ_STAT: s_axi_rdata <= {29'h0, ist_r};
					`SEAL_OFF_IRQ_MASK: s_axi_rdata <= {29'h0, imask_r};
					`SEAL_OFF_LOAD_CNT: s_axi_rdata <= {25'h0, load_cnt_r};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `SEAL_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// software fields of the control word; the engine owns start when it ends
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			start_r  <= 1'b0;
			cmd_r    <= 1'b0;
			div_r    <= 2'h0;
			al_dis_r <= 1'b0;
			fast_r   <= 1'b1;
			addr_r   <= 7'h00;
			data_r   <= 16'h0000;
			imask_r  <= '0;
		end else if (clk_en) begin
			if (wr_go && awa_r == `SEAL_OFF_CTRL) begin
				if (ws_r[0]) begin
					if (!start_r && !busy_r && wd_r[`SEAL_B_START])
						start_r <= 1'b1;
					cmd_r    <= wd_r[`SEAL_B_CMD];
					div_r    <= wd_r[`SEAL_B_DIV_HI:`SEAL_B_DIV_LO];
					al_dis_r <= wd_r[`SEAL_B_AL_DIS];
					fast_r   <= wd_r[`SEAL_B_FAST];
				end
				if (ws_r[1])
					addr_r <= wd_r[`SEAL_B_ADDR_HI:`SEAL_B_ADDR_LO];
				if (ws_r[3:2] == 2'b11 && !start_r)
					data_r <= wd_r[`SEAL_B_DATA_HI:`SEAL_B_DATA_LO];
			end
			if (wr_go && awa_r == `SEAL_OFF_IRQ_MASK && ws_r[0])
				imask_r <= wd_r[`SEAL_IRQ_W-1:0];
			if (fin && !is_auto_r) begin
				start_r <= 1'b0;
				if (!cyc_wr_r)
					data_r <= rx_r;
			end
		end
	end

	// cycle end pulse: stop condition finished
	assign fin = tick && st_r == seal_pkg::ST_STOP && ph_r == 2'h3;

	// serial engine: start, device byte, word address, then data write or restart and read
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_r <= seal_pkg::ST_IDLE;
			div_cnt_r <= 14'h0000;
			ph_r <= 2'h0;
			bit_r <= 3'h0;
			byte_r <= 2'h0;
			sh_r <= 8'h00;
			rx_r <= 16'h0000;
			is_auto_r <= 1'b0;
			restart_r <= 1'b0;
			nack_r <= 1'b0;
			cyc_wr_r <= 1'b0;
			load_cnt_r <= 7'h00;
			al_pend_r <= 1'b1;
			ee_scl_oe <= 1'b0;
			ee_sda_oe <= 1'b0;
		end else if (clk_en) begin
			// idle holds the count at zero so the first quarter of a frame is a full one
			div_cnt_r <= (tick || st_r == seal_pkg::ST_IDLE) ? 14'h0000 : div_cnt_r + 14'h0001;
			unique case (st_r)
				seal_pkg::ST_IDLE: begin
					ee_scl_oe <= 1'b0;
					ee_sda_oe <= 1'b0;
					ph_r <= 2'h0;
					restart_r <= 1'b0;
					nack_r <= 1'b0;
					if (al_pend_r && !al_dis_r && load_cnt_r < `SEAL_LOAD_WORDS) begin
						is_auto_r <= 1'b1;
						cyc_wr_r <= 1'b0;
						st_r <= seal_pkg::ST_START;
					end else if (start_r) begin
						al_pend_r <= 1'b0;
						is_auto_r <= 1'b0;
						cyc_wr_r <= cmd_r;
						st_r <= seal_pkg::ST_START;
					end else
						al_pend_r <= 1'b0;
				end
				seal_pkg::ST_START: if (tick) begin
					// sda falls while scl high; released lines read high
					ph_r <= ph_r + 2'h1;
					ee_scl_oe <= (ph_r == 2'h3);
					ee_sda_oe <= (ph_r >= 2'h2);
					if (ph_r == 2'h3) begin
						sh_r <= (restart_r) ? `SEAL_DEV_RD : `SEAL_DEV_WR;
						byte_r <= restart_r ? 2'h3 : 2'h0;
						bit_r <= 3'h7;
						st_r <= seal_pkg::ST_BYTE;
					end
				end
				seal_pkg::ST_BYTE: if (tick) begin
					ph_r <= ph_r + 2'h1;
					ee_sda_oe <= !sh_r[7];
					ee_scl_oe <= !(ph_r == 2'h1 || ph_r == 2'h2);
					if (ph_r == 2'h3) begin
						sh_r <= {sh_r[6:0], 1'b0};
						bit_r <= bit_r - 3'h1;
						if (bit_r == 3'h0)
							st_r <= seal_pkg::ST_ACK;
					end
				end
				seal_pkg::ST_ACK: if (tick) begin
					ph_r <= ph_r + 2'h1;
					ee_sda_oe <= 1'b0;
					ee_scl_oe <= !(ph_r == 2'h1 || ph_r == 2'h2);
					if (ph_r == 2'h2 && ee_sda_i)
						nack_r <= 1'b1;
					if (ph_r == 2'h3) begin
						byte_r <= byte_r + 2'h1;
						bit_r <= 3'h7;
						if (nack_r)
							st_r <= seal_pkg::ST_STOP;
						else if (byte_r == 2'h0) begin
							sh_r <= {1'b0, is_auto_r ? load_cnt_r : addr_r};
							st_r <= seal_pkg::ST_BYTE;
						end else if (byte_r == 2'h1 && !cyc_wr_r) begin
							restart_r <= 1'b1;
							st_r <= seal_pkg::ST_START;
						end else if (byte_r == 2'h1) begin
							sh_r <= data_r[15:8];
							st_r <= seal_pkg::ST_BYTE;
						end else if (byte_r == 2'h2) begin
							sh_r <= data_r[7:0];
							st_r <= seal_pkg::ST_BYTE;
						end else if (!cyc_wr_r)
							st_r <= seal_pkg::ST_RBYTE;   // read device byte taken
						else
							st_r <= seal_pkg::ST_STOP;    // low data byte taken
					end
				end
				seal_pkg::ST_RBYTE: if (tick) begin
					ph_r <= ph_r + 2'h1;
					ee_sda_oe <= 1'b0;
					ee_scl_oe <= !(ph_r == 2'h1 || ph_r == 2'h2);
					if (ph_r == 2'h2)
						rx_r <= {rx_r[14:0], ee_sda_i};
					if (ph_r == 2'h3) begin
						bit_r <= bit_r - 3'h1;
						if (bit_r == 3'h0)
							st_r <= seal_pkg::ST_MACK;
					end
				end
				seal_pkg::ST_MACK: if (tick) begin
					// ack the high byte, leave the low byte unacked
					ph_r <= ph_r + 2'h1;
					// the byte count wrapped to zero on the read device byte: zero is the high byte
					ee_sda_oe <= (byte_r == 2'h0);
					ee_scl_oe <= !(ph_r == 2'h1 || ph_r == 2'h2);
					if (ph_r == 2'h3) begin
						bit_r <= 3'h7;
						byte_r <= byte_r + 2'h1;
						st_r <= (byte_r == 2'h0) ? seal_pkg::ST_RBYTE : seal_pkg::ST_STOP;
					end
				end
				seal_pkg::ST_STOP: if (tick) begin
					ph_r <= ph_r + 2'h1;
					ee_scl_oe <= (ph_r == 2'h0);
					ee_sda_oe <= (ph_r <= 2'h1);
					if (ph_r == 2'h3) begin
						st_r <= seal_pkg::ST_IDLE;
						if (is_auto_r && !nack_r)
							load_cnt_r <= load_cnt_r + 7'h01;
						if (is_auto_r && nack_r)
							al_pend_r <= 1'b0;    // an unanswered load gives up
					end
				end
			endcase
		end
	end

	// status flags; error holds until the next cycle ends
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			err_r <= 1'b0;
			done_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (clk_en) begin
			if (fin)
				err_r <= nack_r;
			busy_r <= (st_r != seal_pkg::ST_IDLE && is_auto_r) ||
				(st_r == seal_pkg::ST_IDLE && al_pend_r && !al_dis_r);
			if (fin && is_auto_r && !nack_r && load_cnt_r == `SEAL_LOAD_WORDS - 7'h01)
				done_r <= 1'b1;
		end
	end

	// word handed to the configuration space after each acknowledged autoload read
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			load_we <= 1'b0;
			load_addr <= 7'h00;
			load_data <= 16'h0000;
		end else if (clk_en) begin
			load_we <= fin && is_auto_r && !nack_r;
			if (fin && is_auto_r) begin
				load_addr <= load_cnt_r;
				load_data <= rx_r;
			end
		end
	end

	// sticky events, set wins over write-one-to-clear
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			ist_r <= '0;
		else if (clk_en) begin
			if (wr_go && awa_r == `SEAL_OFF_IRQ_STAT && ws_r[0])
				ist_r <= ist_r & ~wd_r[`SEAL_IRQ_W-1:0];
			if (fin && !is_auto_r)
				ist_r[`SEAL_IRQ_CYC] <= 1'b1;
			if (fin && nack_r)
				ist_r[`SEAL_IRQ_ERR] <= 1'b1;
			if (fin && is_auto_r && !nack_r && load_cnt_r == `SEAL_LOAD_WORDS - 7'h01)
				ist_r[`SEAL_IRQ_LOAD] <= 1'b1;
		end
	end

	assign irq = |(ist_r & imask_r);
	// lines are open drain: output value is always low, enable pulls
	assign ee_scl_o = 1'b0;
	assign ee_sda_o = 1'b0;

	property p_start_clears;
		@(posedge mclk) disable iff (reset) fin && !is_auto_r |=> !start_r;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("start not cleared");

	property p_busy_auto;
		@(posedge mclk) disable iff (reset)
			clk_en && st_r != seal_pkg::ST_IDLE && is_auto_r |=> busy_r;
	endproperty
	a_busy_auto: assert property (p_busy_auto) else $error("busy low during load");

	property p_no_auto_dis;
		@(posedge mclk) disable iff (reset)
			st_r == seal_pkg::ST_IDLE && al_dis_r && clk_en |=> !is_auto_r || st_r == seal_pkg::ST_IDLE;
	endproperty
	a_no_auto_dis: assert property (p_no_auto_dis) else $error("autoload while disabled");

	property p_err_set;
		@(posedge mclk) disable iff (reset) fin && nack_r |=> err_r;
	endproperty
	a_err_set: assert property (p_err_set) else $error("error flag missed");

	property p_done_ok;
		@(posedge mclk) disable iff (reset) $rose(done_r) |-> $past(is_auto_r) && !$past(nack_r);
	endproperty
	a_done_ok: assert property (p_done_ok) else $error("complete without good load");

	property p_read_data;
		@(posedge mclk) disable iff (reset) fin && !is_auto_r && !cyc_wr_r |=> data_r == $past(rx_r);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read word not stored");

	property p_tick_span;
		@(posedge mclk) disable iff (reset) tick |-> div_cnt_r == div_lim;
	endproperty
	a_tick_span: assert property (p_tick_span) else $error("divider tick off");

	property p_launch;
		@(posedge mclk) disable iff (reset)
			$rose(start_r) && !al_pend_r && clk_en |=> st_r == seal_pkg::ST_START;
	endproperty
	a_launch: assert property (p_launch) else $error("cycle did not launch");
endmodule

// ==== testbench/seal_ee_model.sv ====
// behavioural two-wire eeprom of 128 sixteen-bit words for the loader bench
// assumes open-drain lines resolved by the bench with pull-ups
`timescale 1ns/1ps
module seal_ee_model (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic nack,
	output logic      sda_low
);
	logic [15:0] mem [0:127];
	logic [15:0] outw;
	logic [7:0]  sh;
	logic [6:0]  wa;
	logic        act;
	logic        rd;
	int          cnt;
	int          byn;
	int          nb;
	// idle: nothing driven, so the pull-up shows on the line
	initial begin
		act = 0;
		rd = 0;
		sda_low = 0;
		wa = 0;
		outw = 0;
	end
	// start or repeated start; the first clock fall only ends the start
	always @(negedge sda) if (scl === 1'b1) begin
		act = 1;
		rd = 0;
		cnt = -1;
		byn = 0;
	end
	// stop frees the line
	always @(posedge sda) if (scl === 1'b1) begin
		act = 0;
		sda_low = 0;
	end
	// master bits are taken while the clock is high
	always @(posedge scl) if (act && !rd && cnt < 8) sh = {sh[6:0], sda};
	// own drive only changes with the clock low, so it never fakes a start or stop
	always @(negedge scl) if (act) begin
		cnt++;
		if (cnt == 9) cnt = 0;
		sda_low = 0;
		if (cnt == 8 && !rd) begin
			sda_low = !nack; // a refusing part leaves the acknowledge high
			case (byn)
				0: if (sh == 8'ha1) begin
					rd = 1;
					outw = mem[wa];
					nb = 0;
				end
				1: wa = sh[6:0];
				2: outw[7:0] = sh;
				3: mem[wa] = {outw[7:0], sh};
				default: ;
			endcase
			byn++;
		end else if (rd && cnt != 8 && nb < 16) begin
			sda_low = !outw[15];
			outw = {outw[14:0], 1'b0};
			nb++;
		end
	end
endmodule

// ==== testbench/serial_eeprom_access_autoload_test.sv ====
// self-checking bench: axi4-lite master, eeprom model and interrupt checks
// assumes the design and the eeprom model are compiled first
`timescale 1ns/1ps
`include "seal_consts.svh"
module serial_eeprom_access_autoload_test;
	logic        mclk, reset, awvalid, wvalid, bready, arvalid, rready, nack, sda_low, clk_en;
	logic        awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, irq, lwe;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, g;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] d1, d2, ldat;
	logic [6:0]  a2, laddr;
	int          num_errors, cmp_count, i;
	wire         sda = !(sda_oe | sda_low);
	wire         scl = !scl_oe;

	seal_top seal_top_inst (.mclk(mclk), .reset(reset), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ee_scl_o(), .ee_scl_oe(scl_oe),
		.ee_sda_o(), .ee_sda_oe(sda_oe), .ee_sda_i(sda), .load_we(lwe),
		.load_addr(laddr), .load_data(ldat), .irq(irq));
	seal_ee_model seal_ee_model_inst (.scl(scl), .sda(sda), .nack(nack), .sda_low(sda_low));

	// 100 ns clock
	always #50 mclk = ~mclk;

	// expected control word with divider 11, fast bit kept, no autoload state
	function automatic logic [31:0] ctl(input logic [15:0] d, input logic [6:0] a,
		input logic e, input logic c);
		return {d, a, 1'b0, 1'b1, 1'b0, 2'b11, 1'b0, e, c, 1'b0};
	endfunction

	// register word compare
	task automatic cmpw(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// response code or level compare
	task automatic cmps(input logic [1:0] got, input logic [1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// verdict and end of run
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge mclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 100) num_errors++;
	endtask

	// read: data and response taken at the edge that sees rvalid
	task automatic axr(input logic [7:0] a);
		int n;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge mclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		g = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n == 100) num_errors++;
	endtask

	// poll; fields are left alone until start and in-progress both read zero
	task automatic wait_idle;
		int n;
		for (n = 0; n < 3000; n++) begin
			repeat (20) @(posedge mclk);
			axr(`SEAL_OFF_CTRL);
			if ((g & 32'h101) == 32'h0) break;
		end
		if (n == 3000) num_errors++;
	endtask

	// fields first with start low, then the start edge, then wait
	task automatic sw(input logic [6:0] a, input logic [15:0] d, input logic c);
		axw(`SEAL_OFF_CTRL, ctl(d, a, 1'b0, c));
		axw(`SEAL_OFF_CTRL, ctl(d, a, 1'b0, c) | 32'h1);
		wait_idle();
	endtask

	// main sequence
	initial begin
		mclk = 0;
		reset = 1;
		clk_en = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		nack = 1;
		num_errors = 0;
		cmp_count = 0;
		i = $urandom(32'h4151438b);
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		axr(`SEAL_OFF_CTRL);
		cmpw(g, 32'h0000_0180);
		$display("test reset values done");
		// the part refuses the autoload: error set, complete stays clear
		wait_idle();
		cmpw(g, 32'h0000_0084);
		// a refused load hands no word to the configuration space
		cmpw({lwe, 8'h0, laddr, ldat}, 32'h0);
		axr(`SEAL_OFF_IRQ_STAT);
		cmpw(g & 32'h2, 32'h2);
		cmps({1'b0, irq}, 2'h0);
		axw(`SEAL_OFF_IRQ_MASK, 32'h2);
		@(posedge mclk);
		cmps({1'b0, irq}, 2'h1);
		axw(`SEAL_OFF_IRQ_STAT, 32'h7);
		repeat (2) @(posedge mclk);
		cmps({1'b0, irq}, 2'h0);
		axw(8'h40, 32'hffff_ffff);
		cmps(r, `SEAL_RESP_SLVERR);
		axr(8'h00);
		cmps(r, `SEAL_RESP_SLVERR);
		cmpw(g, 32'h0);
		axw(`SEAL_OFF_IRQ_MASK, 32'h7);
		$display("test autoload refusal done");
		// write to the top word, read it back over other data, then a preloaded word
		nack <= 1'b0;
		d1 = 16'($urandom);
		sw(7'h7f, d1, 1'b1);
		cmpw(g, ctl(d1, 7'h7f, 1'b0, 1'b1));
		cmpw({16'h0, seal_ee_model_inst.mem[7'h7f]}, {16'h0, d1});
		sw(7'h7f, ~d1, 1'b0);
		cmpw(g, ctl(d1, 7'h7f, 1'b0, 1'b0));
		a2 = 7'($urandom);
		d2 = 16'($urandom);
		seal_ee_model_inst.mem[a2] = d2;
		sw(a2, 16'h0, 1'b0);
		cmpw(g, ctl(d2, a2, 1'b0, 1'b0));
		axr(`SEAL_OFF_IRQ_STAT);
		cmpw(g & 32'h1, 32'h1);
		cmps({1'b0, irq}, 2'h1);
		$display("test software cycles done");
		// refused software read still ends with start low and the error raised
		nack <= 1'b1;
		axw(`SEAL_OFF_CTRL, ctl(16'h0, 7'h0, 1'b0, 1'b0));
		axw(`SEAL_OFF_CTRL, ctl(16'h0, 7'h0, 1'b0, 1'b0) | 32'h1);
		// a low enable must freeze the lines in mid-frame; a running engine ticks every 64
		repeat (70) @(posedge mclk);
		clk_en <= 1'b0;
		@(posedge mclk);
		r = {scl_oe, sda_oe};
		i = 0;
		repeat (200) begin
			@(posedge mclk);
			if ({scl_oe, sda_oe} !== r) i++;
		end
		clk_en <= 1'b1;
		cmpw(i, 32'h0);
		wait_idle();
		cmpw(g & 32'hffff, 32'h0000_00b4);
		$display("test software refusal done");
		end_of_test();
	end

	// cut a hang short; the tests need a little over half of this span
	initial begin
		#(90_000 * 100);
		num_errors++;
		end_of_test();
	end
endmodule
